//--- uic_pkg.sv
// Purpose: shared constants and types for the serial-port interrupt and enable control
// Assumes: plain register port, one clock, asynchronous active-low reset
// Notes: word offsets on the register port; data is 8 bits wide
package uic_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int NUM_SRC = 4;
   // register offsets
   localparam logic [3:0] OFF_CTRL = 4'h0;  // control_reg_one
   localparam logic [3:0] OFF_MASK = 4'h1;  // interrupt_mask_reg
   localparam logic [3:0] OFF_FLAG = 4'h2;  // interrupt_flag_reg (read raw, write 1 sets)
   localparam logic [3:0] OFF_CLR = 4'h3;   // write 1 clears flags
   localparam logic [3:0] OFF_MSTAT = 4'h4; // flags gated by mask, read only
   localparam logic [3:0] OFF_VEC = 4'h5;   // vector, read clears top flag
   // source bit positions, lowest index has highest priority
   localparam int SRC_RX = 0;     // rx_char_irq
   localparam int SRC_TX = 1;     // tx_ready_irq
   localparam int SRC_ERR = 2;    // received erroneous character
   localparam int SRC_BRK = 3;    // break_char_irq
   localparam int CTRL_EN_BIT = 0;
   // reset values
   localparam logic CTRL_EN_RST = 1'b0;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [3:0] FLAG_RST = 4'h0;
   localparam logic [7:0] RDATA_RST = 8'h00;
   // vector codes: 0 none, else 2*(index+1)
   localparam logic [7:0] VEC_NONE = 8'h00;
   typedef logic [NUM_SRC-1:0] uic_src_t;
endpackage

//--- uic_src_if.sv
// Purpose: carries interrupt source state between the control top and its encoder
// Assumes: all signals in the one clock domain
// Notes: combinational path only
`timescale 1ns/100ps
interface uic_src_if;
   import uic_pkg::*;
   uic_src_t active;       // enabled pending sources
   logic [7:0] vecCode;    // vector code of winner
   uic_src_t winner;       // one-hot of winner, zero if none
   modport ctl (output active, input vecCode, input winner);
   modport enc (input active, output vecCode, output winner);
endinterface

//--- uic_prio_enc.sv
// Purpose: picks the highest-priority enabled pending source
// Assumes: lowest bit index is highest priority
// Notes: pure combinational
`timescale 1ns/100ps
module uic_prio_enc (
   uic_src_if.enc src
);
   import uic_pkg::*;
   // scan from lowest priority upward so the highest one wins last
   always_comb begin
      src.vecCode = VEC_NONE;
      src.winner = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (src.active[i]) begin
            src.vecCode = 8'((i + 1) * 2);
            src.winner = uic_src_t'(1 << i);
         end
      end
   end
endmodule

//--- uic_ctrl.sv
// Purpose: interrupt flags, masks, vector and module enable of a serial port
// Assumes: one-cycle strobes, read data valid the cycle after the read strobe
// Notes: hardware set wins over any clear in the same cycle
// Function
// - writing the clear register drops each selected pending flag
// - vector read drops the highest-priority pending enabled flag
// - only enabled pending sources drive the interrupt output
// - receive, transmit-ready and error sources each have a mask bit
// - break character is a separately enabled source
// - clearing module enable halts transmit and receive
// - setting module enable resumes transmit and receive
// - a read of the masked status register returns flags gated by their enables
`timescale 1ns/100ps
module uic_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [uic_pkg::ADDR_W-1:0] regAddr,
   input wire logic [uic_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [uic_pkg::DATA_W-1:0] regRdata,
   input wire logic rxCharEvt,
   input wire logic txReadyEvt,
   input wire logic rxErrEvt,
   input wire logic breakCharEvt,
   output logic portEnable,
   output logic irqOut
);
   import uic_pkg::*;

   typedef struct packed {
      logic ctrlEn;
      uic_src_t mask;
      uic_src_t flags;
      logic [DATA_W-1:0] rdata;
      logic irq;
   } uic_state_t;

   uic_state_t state_reg;
   uic_state_t state_next;
   uic_src_t hwSet;
   uic_src_t clrSel;
   uic_src_t setSel;

   uic_src_if srcBus ();

   uic_prio_enc u_prio (
      .src(srcBus)
   );

   // gate raw events while the port is halted
   // halt when off
   always_comb begin
      hwSet = '0;
      hwSet[SRC_RX] = rxCharEvt & state_reg.ctrlEn;
      hwSet[SRC_TX] = txReadyEvt & state_reg.ctrlEn;
      hwSet[SRC_ERR] = rxErrEvt & state_reg.ctrlEn;
      hwSet[SRC_BRK] = breakCharEvt & state_reg.ctrlEn;
   end

   assign srcBus.active = state_reg.flags & state_reg.mask;

   // software sets and clears: flag register write sets, explicit clear register plus vector read clear
   always_comb begin
      clrSel = '0;
      setSel = '0;
      if (regWr && regAddr == OFF_CLR) begin
         clrSel = regWdata[NUM_SRC-1:0];
      end
      if (regWr && regAddr == OFF_FLAG) begin
         setSel = regWdata[NUM_SRC-1:0];
      end
      if (regRd && regAddr == OFF_VEC) begin
         clrSel = srcBus.winner;
      end
   end

   // next state; hardware set beats clear so no event is lost
   always_comb begin
      state_next = state_reg;
      state_next.flags = (state_reg.flags & ~clrSel) | setSel | hwSet;
      state_next.rdata = RDATA_RST;
      if (regWr) begin
         case (regAddr)
            OFF_CTRL: begin
               state_next.ctrlEn = regWdata[CTRL_EN_BIT];
            end
            OFF_MASK: begin
               state_next.mask = regWdata[NUM_SRC-1:0];
            end
            default: begin
            end
         endcase
      end
      if (regRd) begin
         case (regAddr)
            OFF_CTRL: state_next.rdata = {7'h00, state_reg.ctrlEn};
            OFF_MASK: state_next.rdata = {4'h0, state_reg.mask};
            OFF_FLAG: state_next.rdata = {4'h0, state_reg.flags};
            OFF_MSTAT: state_next.rdata = {4'h0, srcBus.active};
            OFF_VEC: state_next.rdata = srcBus.vecCode;
            default: state_next.rdata = RDATA_RST; // unmapped reads zero
         endcase
      end
      state_next.irq = |(state_next.flags & state_next.mask);
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '{ctrlEn: CTRL_EN_RST, mask: MASK_RST, flags: FLAG_RST,
                        rdata: RDATA_RST, irq: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops
   assign regRdata = state_reg.rdata;
   assign portEnable = state_reg.ctrlEn;
   assign irqOut = state_reg.irq;
endmodule

//--- uic_remote_model.sv
// Purpose: remote serial device raising line events
// Assumes: one event pulse per fire request
// Notes: registered so events never race the bench
`timescale 1ns/100ps
module uic_remote_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] fire,
   output logic [3:0] evt
);
   // bit order rx, tx ready, error, break
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) evt <= 4'h0;
      else evt <= fire;
   end
endmodule

//--- uic_ctrl_monitor.sv
// Purpose: port-level checks for uic_ctrl
// Assumes: one clock, reset low disables checks
// Notes: flags are hidden, so checks lean on irqOut
`timescale 1ns/100ps
module uic_ctrl_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [uic_pkg::ADDR_W-1:0] regAddr,
   input wire logic [uic_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [uic_pkg::DATA_W-1:0] regRdata,
   input wire logic rxCharEvt,
   input wire logic txReadyEvt,
   input wire logic rxErrEvt,
   input wire logic breakCharEvt,
   input wire logic portEnable,
   input wire logic irqOut
);
   import uic_pkg::*;
   logic evtAny;
   // any line event in this cycle
   assign evtAny = rxCharEvt | txReadyEvt | rxErrEvt | breakCharEvt;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_en_write: assert property (regWr && regAddr == OFF_CTRL |=>
      portEnable == $past(regWdata[0])) else $error("enable bit wrong");
   a_halt_quiet: assert property (!portEnable && !regWr && !irqOut |=> !irqOut)
      else $error("event taken while halted");
   a_clear_all: assert property (regWr && regAddr == OFF_CLR && regWdata[3:0] == 4'hf
      && !evtAny |=> !irqOut) else $error("clear left irq");
   a_irq_cause: assert property ($rose(irqOut) |-> $past(regWr || portEnable && evtAny))
      else $error("irq without cause");
   a_vec_none: assert property (regRd && regAddr == OFF_VEC && !irqOut |=>
      regRdata == VEC_NONE) else $error("vector not zero");
   a_vec_some: assert property (regRd && regAddr == OFF_VEC && irqOut |=>
      regRdata inside {8'h02, 8'h04, 8'h06, 8'h08}) else $error("bad vector");
   a_mstat_gate: assert property (regRd && regAddr == OFF_MSTAT |=>
      (regRdata != 8'h00) == $past(irqOut)) else $error("gated flags wrong");
   a_rdata_idle: assert property (!regRd |=> regRdata == RDATA_RST)
      else $error("read data not idle");
   c_vec_read: cover property (regRd && regAddr == OFF_VEC && irqOut);
   c_irq_rise: cover property ($rose(irqOut));
   c_halt_evt: cover property (!portEnable && evtAny);
endmodule
bind uic_ctrl uic_ctrl_monitor u_mon (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
   .rxCharEvt(rxCharEvt), .txReadyEvt(txReadyEvt), .rxErrEvt(rxErrEvt),
   .breakCharEvt(breakCharEvt), .portEnable(portEnable), .irqOut(irqOut));

//--- tb_top.sv
// Purpose: self-checking bench for uic_ctrl
// Assumes: remote model pulses each event one cycle
// Notes: directed scenarios only
`timescale 1ns/100ps
module tb_top;
   import uic_pkg::*;
   logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, portEnable, irqOut;
   logic [3:0] regAddr = 4'h0, fire = 4'h0, evt;
   logic [7:0] regWdata = 8'h00, regRdata;
   int num_errors = 0, comparisons = 0;
   uic_ctrl u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .rxCharEvt(evt[0]),
      .txReadyEvt(evt[1]), .rxErrEvt(evt[2]), .breakCharEvt(evt[3]),
      .portEnable(portEnable), .irqOut(irqOut));
   uic_remote_model u_far (.clk(clk), .rst_n(rst_n), .fire(fire), .evt(evt));
   // clock, and a watchdog far beyond the roughly 70 cycles used
   initial forever #2 clk = ~clk;
   initial begin
      #20000 num_errors++;
      complete_run();
   end
   task complete_run;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(logic [7:0] got, logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // bus cycles: strobe one cycle, read data checked in the cycle after
   task wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge clk) regWr <= 1'b0;
   endtask
   task rd(logic [3:0] a, logic [7:0] e);
      @(posedge clk) {regRd, regAddr} <= {1'b1, a};
      @(posedge clk) regRd <= 1'b0;
      #1 chk(regRdata, e);
   endtask
   // event reaches the design one edge after fire is raised, flags latch it on the next edge
   task ev(logic [3:0] f);
      @(posedge clk) fire <= f;
      @(posedge clk) fire <= 4'h0;
      @(posedge clk);
   endtask
   task t_gate;
      wr(OFF_CTRL, 8'h01);
      ev(4'h1);
      #1 chk(8'(irqOut), 8'h00);
      rd(OFF_MSTAT, 8'h00);
      rd(OFF_FLAG, 8'h01);
      wr(OFF_CLR, 8'h01);
      wr(OFF_MASK, 8'h0f);
      #1 chk(8'(irqOut), 8'h00);
      ev(4'h1);
      #1 chk(8'(irqOut), 8'h01);
      $display("gate test done");
   endtask
   task t_vec;
      ev(4'hf);
      for (int i = 1; i <= 4; i++) rd(OFF_VEC, 8'(2 * i));
      rd(OFF_VEC, VEC_NONE);
      #1 chk(8'(irqOut), 8'h00);
      $display("vector test done");
   endtask
   task t_clear;
      wr(OFF_FLAG, 8'h0f);
      wr(OFF_CLR, 8'h05);
      rd(OFF_FLAG, 8'h0a);
      wr(OFF_MASK, 8'h04);
      rd(OFF_MSTAT, 8'h00);
      rd(OFF_VEC, VEC_NONE);
      $display("clear test done");
   endtask
   task t_enable;
      wr(OFF_MASK, 8'h0f);
      wr(OFF_CLR, 8'h0f);
      wr(OFF_CTRL, 8'h00);
      #1 chk(8'(portEnable), 8'h00);
      ev(4'hf);
      rd(OFF_FLAG, 8'h00);
      wr(OFF_CTRL, 8'h01);
      ev(4'h8);
      rd(OFF_FLAG, 8'h08);
      rd(OFF_VEC, 8'h08);
      rd(OFF_CTRL, 8'h01);
      rd(OFF_MASK, 8'h0f);
      rd(4'hf, 8'h00);
      $display("enable test done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_gate();
      t_vec();
      t_clear();
      t_enable();
      complete_run();
   end
endmodule
